//--- fiowd_top.sv
// Field I/O outputs, inputs, watchdogs, 1 kHz timebase and comm-loss logic
`timescale 1ns/1ps
`default_nettype none
`include "fiowd_params.svh"

// Overview of operation
// - 64 outputs latch written value until reset
// - Reset clears every output latch to zero
// - Logic one sinks line, zero leaves open
// - Power-up and power-down keep drivers open
// - All outputs update in one clock
// - Unchanged outputs never glitch during writes
// - Inputs ground-true: low line reads one
// - Jumper fitted: toggle bit 39 every 100 ms, stopping after 100 toggles (10 s)
// - No jumper: no automatic toggling
// - Module watchdog enabled at power-up, 100 ms
// - Watchdog enabled flag in status byte
// - Watchdog cannot be disabled once enabled
// - Watchdog expiry pulses module hardware reset
// - Resynchronizable 1 kHz reference from clock
// - 32-bit millisecond counter increments per tick
// - Comm loss flagged until status request
// - Switch isolates port three; indicator when active
// - Two seconds silence forces outputs off
module fiowd_top import fiowd_pkg::*; #(
    parameter int CLK_HZ = `FIOWD_CLK_HZ,
    parameter int MS_CYCLES = CLK_HZ / `FIOWD_MS_HZ,
    parameter int TOGGLE_MS = `FIOWD_TOGGLE_MS,
    parameter int TOGGLE_COUNT = `FIOWD_TOGGLE_COUNT,
    parameter int MWD_TIMEOUT_MS = `FIOWD_MWD_TIMEOUT_MS,
    parameter int COMM_LOSS_MS = `FIOWD_COMM_LOSS_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Output write from the controller
    input wire logic out_wr,
    input wire logic [63:0] out_wr_mask,
    input wire logic [63:0] out_wr_data,
    input wire logic power_down,
    // Field output pins, open drain: oe low means sinking
    output logic [63:0] field_out_o,
    output logic [63:0] field_out_oe_n,
    // Field inputs
    input wire logic [63:0] field_in,
    output logic [63:0] in_data,
    // Watchdogs
    input wire logic ext_wdt_jumper,
    input wire logic mwd_service,
    input wire logic mwd_disable_req,
    output logic module_hw_reset,
    // Timebase
    input wire logic ms_sync,
    output logic ms_tick,
    output logic [31:0] millisecond_counter,
    // Communication
    input wire logic comm_valid,
    input wire logic status_req,
    output logic [7:0] status_byte,
    // Serial port three isolation
    input wire logic port_switch,
    input wire logic serial_port_three_active,
    output logic port_connect,
    output logic port_active_indicator
);
    localparam int PW = $clog2(MS_CYCLES + 1);
    localparam int TW = $clog2(TOGGLE_MS + 1);
    localparam int NW = $clog2(TOGGLE_COUNT + 1);
    localparam int WW = $clog2(MWD_TIMEOUT_MS + 1);
    localparam int CW = $clog2(COMM_LOSS_MS + 1);

    logic [63:0] out_q, out_d;
    logic [63:0] oe_n_q, oe_n_d;
    logic [63:0] in_q, in_d;
    logic [PW-1:0] pre_q, pre_d;
    logic tick_q, tick_d;
    fiowd_ms_t ms_q, ms_d;
    logic [TW-1:0] tog_q, tog_d;
    logic [NW-1:0] togn_q, togn_d;
    logic mwd_en_q, mwd_en_d;
    logic [WW-1:0] mwd_q, mwd_d;
    logic hwrst_q, hwrst_d;
    logic [CW-1:0] silent_q, silent_d;
    logic timeout_q, timeout_d;
    logic eflag_q, eflag_d;
    logic conn_q, conn_d;
    logic led_q, led_d;
    logic toggle_now;

    always_comb begin
        // 1 kHz reference; ms_sync restarts the period
        tick_d = 1'b0;
        pre_d = pre_q + PW'(1);
        if (ms_sync) begin
            pre_d = '0;
        end else if (pre_q == PW'(MS_CYCLES - 1)) begin
            pre_d = '0;
            tick_d = 1'b1;
        end
        ms_d = tick_q ? ms_q + 32'h0000_0001 : ms_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pre_q <= '0;
            tick_q <= 1'b0;
            ms_q <= '0;
        end else begin
            pre_q <= pre_d;
            tick_q <= tick_d;
            ms_q <= ms_d;
        end
    end

    // External watchdog toggle on bit 39; counts pause while the jumper is out
    always_comb begin
        toggle_now = 1'b0;
        tog_d = tog_q;
        togn_d = togn_q;
        if (ext_wdt_jumper && togn_q != NW'(TOGGLE_COUNT) && tick_q) begin
            if (tog_q == TW'(TOGGLE_MS - 1)) begin
                tog_d = '0;
                togn_d = togn_q + NW'(1);
                toggle_now = 1'b1;
            end else begin
                tog_d = tog_q + TW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tog_q <= '0;
            togn_q <= '0;
        end else begin
            tog_q <= tog_d;
            togn_q <= togn_d;
        end
    end

    // Output latches: a write changes only masked bits; the watchdog toggle flips bit 39
    always_comb begin
        out_d = out_q;
        if (out_wr) begin
            out_d = (out_q & ~out_wr_mask) | (out_wr_data & out_wr_mask);
        end
        if (toggle_now) begin
            out_d[`FIOWD_WDT_BIT] = ~out_d[`FIOWD_WDT_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    // Communication loss timing; a timeout set wins over a status request
    always_comb begin
        silent_d = silent_q;
        timeout_d = timeout_q;
        if (comm_valid) begin
            silent_d = '0;
            timeout_d = 1'b0;
        end else if (tick_q && !timeout_q) begin
            if (silent_q == CW'(COMM_LOSS_MS - 1)) begin
                timeout_d = 1'b1;
            end else begin
                silent_d = silent_q + CW'(1);
            end
        end
        eflag_d = eflag_q;
        if (status_req) begin
            eflag_d = 1'b0;
        end
        if (timeout_d) begin
            eflag_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            silent_q <= '0;
            timeout_q <= 1'b0;
            eflag_q <= 1'b1;
        end else begin
            silent_q <= silent_d;
            timeout_q <= timeout_d;
            eflag_q <= eflag_d;
        end
    end

    // Drivers: one sinks, zero or power-down or comm loss opens
    always_comb begin
        oe_n_d = ~out_d;
        if (power_down || timeout_d) begin
            oe_n_d = '1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            oe_n_q <= '1;
        end else begin
            oe_n_q <= oe_n_d;
        end
    end

    // Inputs: ground-true lines are inverted as they are registered
    always_comb begin
        in_d = ~field_in;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            in_q <= '0;
        end else begin
            in_q <= in_d;
        end
    end

    // Module watchdog, enabled from reset, disable ignored
    always_comb begin
        mwd_en_d = 1'b1;
        hwrst_d = 1'b0;
        mwd_d = mwd_q;
        if (mwd_service) begin
            mwd_d = WW'(MWD_TIMEOUT_MS);
        end else if (tick_q && mwd_en_q) begin
            if (mwd_q == WW'(1)) begin
                hwrst_d = 1'b1;
                mwd_d = WW'(MWD_TIMEOUT_MS);
            end else begin
                mwd_d = mwd_q - WW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mwd_en_q <= 1'b1;
            mwd_q <= WW'(MWD_TIMEOUT_MS);
            hwrst_q <= 1'b0;
        end else begin
            mwd_en_q <= mwd_en_d;
            mwd_q <= mwd_d;
            hwrst_q <= hwrst_d;
        end
    end

    // Serial port three isolation and its indicator
    always_comb begin
        conn_d = port_switch;
        led_d = port_switch && serial_port_three_active;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            conn_q <= 1'b0;
            led_q <= 1'b0;
        end else begin
            conn_q <= conn_d;
            led_q <= led_d;
        end
    end

    assign field_out_o = '0;
    assign field_out_oe_n = oe_n_q;
    assign in_data = in_q;
    assign module_hw_reset = hwrst_q;
    assign ms_tick = tick_q;
    assign millisecond_counter = ms_q;
    assign status_byte = {6'h00, mwd_en_q, eflag_q};
    assign port_connect = conn_q;
    assign port_active_indicator = led_q;
endmodule
`default_nettype wire

//--- fiowd_params.svh
// Constants for the field I/O output, watchdog and timebase block
`ifndef FIOWD_PARAMS_SVH
`define FIOWD_PARAMS_SVH

`define FIOWD_CLK_HZ 50000000
`define FIOWD_NUM_IO 64
`define FIOWD_WDT_BIT 39
`define FIOWD_MS_HZ 1000
`define FIOWD_MS_CYCLES (`FIOWD_CLK_HZ / `FIOWD_MS_HZ)
`define FIOWD_TOGGLE_MS 100
`define FIOWD_TOGGLE_SEC 10
`define FIOWD_TOGGLE_COUNT (`FIOWD_TOGGLE_SEC * 1000 / `FIOWD_TOGGLE_MS)
`define FIOWD_MWD_TIMEOUT_MS 100
`define FIOWD_COMM_LOSS_MS 2000
`define FIOWD_STAT_COMM_LOSS 0
`define FIOWD_STAT_WD_EN 1
`define FIOWD_STAT_WIDTH 8

`endif

//--- fiowd_pkg.sv
// Types for the field I/O output, watchdog and timebase block
package fiowd_pkg;
    typedef logic [31:0] fiowd_ms_t;
    typedef logic [7:0] fiowd_stat_t;
endpackage

//--- fiowd_assertions.sv
// Checker for the field I/O watchdog and timebase block
`timescale 1ns/1ps
`default_nettype none
module fiowd_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic power_down,
    input wire logic [63:0] field_out_o,
    input wire logic [63:0] field_out_oe_n,
    input wire logic [63:0] field_in,
    input wire logic [63:0] in_data,
    input wire logic mwd_disable_req,
    input wire logic [7:0] status_byte,
    input wire logic ms_tick,
    input wire logic [31:0] millisecond_counter,
    input wire logic port_connect,
    input wire logic port_active_indicator
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_pd; power_down |=> &field_out_oe_n; endproperty
    a_pd: assert property (p_pd) else $error("drivers not open");
    property p_rs; $rose(rst_b) |-> &field_out_oe_n && status_byte == 8'h03; endproperty
    a_rs: assert property (p_rs) else $error("bad reset state");
    property p_in; $past(rst_b) |-> in_data == ~$past(field_in); endproperty
    a_in: assert property (p_in) else $error("input polarity");
    property p_od; field_out_o == 64'h0; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_en; status_byte[1]; endproperty
    a_en: assert property (p_en) else $error("enable flag low");
    property p_ds; mwd_disable_req |=> status_byte[1] ##1 status_byte[1]; endproperty
    a_ds: assert property (p_ds) else $error("watchdog disabled");
    property p_mc; ms_tick |=> millisecond_counter == $past(millisecond_counter) + 32'h1; endproperty
    a_mc: assert property (p_mc) else $error("counter step");
    property p_gap; ms_tick |=> !ms_tick [*8]; endproperty
    a_gap: assert property (p_gap) else $error("tick too early");
    property p_led; port_active_indicator |-> port_connect; endproperty
    a_led: assert property (p_led) else $error("indicator on while isolated");
endmodule
bind fiowd_top fiowd_chk u_chk (.*);
`default_nettype wire

//--- fiowd_ctrl_model.sv
// Controller model that keeps the link alive
`timescale 1ns/1ps
`default_nettype none
module fiowd_ctrl_model (
    input wire logic mclk,
    input wire logic alive,
    output logic comm_valid
);
    int n = 0;
    initial comm_valid = 1'b0;
    always @(negedge mclk) begin
        n = (n + 1) % 50;
        comm_valid <= alive && n == 0;
    end
endmodule
`default_nettype wire

//--- fiowd_top_tb_top.sv
// Testbench for the field I/O watchdog and timebase block
`timescale 1ns/1ps
`default_nettype none
module fiowd_top_tb_top;
    logic mclk = 0, rst_b = 0, wr = 0, pd = 0, svc = 0, dis = 0, sreq = 0, alive = 1, cv;
    logic jmp = 0, sync = 0, psw = 1, pact = 1, pcon, pled;
    logic [63:0] msk = 0, dat = 0, fin = 0, oe_n, ind, fo;
    logic hw, tick;
    logic [31:0] mc, v;
    logic [7:0] st;
    int failures = 0, checks = 0, n;
    fiowd_top #(.MS_CYCLES(10), .COMM_LOSS_MS(20), .MWD_TIMEOUT_MS(5), .TOGGLE_MS(3), .TOGGLE_COUNT(4)) dut (
        .mclk(mclk), .rst_b(rst_b), .out_wr(wr), .out_wr_mask(msk), .out_wr_data(dat), .power_down(pd),
        .field_out_o(fo), .field_out_oe_n(oe_n), .field_in(fin), .in_data(ind), .ext_wdt_jumper(jmp),
        .mwd_service(svc), .mwd_disable_req(dis), .module_hw_reset(hw), .ms_sync(sync), .ms_tick(tick),
        .millisecond_counter(mc), .comm_valid(cv), .status_req(sreq), .status_byte(st),
        .port_switch(psw), .serial_port_three_active(pact), .port_connect(pcon), .port_active_indicator(pled));
    fiowd_ctrl_model ctrl (.mclk(mclk), .alive(alive), .comm_valid(cv));
    initial forever #10 mclk = ~mclk;
    task automatic cyc(input int k); repeat (k) @(negedge mclk); endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_out;
        wr = 1; msk = '1; dat = 64'h00ff_0000_a5a5_8001; cyc(1);
        wr = 0; chk(oe_n, ~dat);
        wr = 1; msk = 64'hffff_ffff; dat = 0; cyc(1);
        wr = 0; cyc(4); chk(oe_n, 64'hff00_ffff_ffff_ffff);
        pd = 1; cyc(1); chk(oe_n, '1);
        pd = 0; cyc(1); chk(oe_n, 64'hff00_ffff_ffff_ffff);
    endtask
    task automatic t_misc;
        fin = 64'h0123_4567_89ab_cdef; cyc(1); chk(ind, ~fin);
        sreq = 1; dis = 1; cyc(1);
        sreq = 0; dis = 0; cyc(1); chk(st, 8'h02);
        n = 0; while (tick !== 1'b1 && n < 20) begin cyc(1); n++; end
        cyc(2); v = mc; cyc(10); chk(mc, v + 1);
    endtask
    task automatic t_wd;
        n = 0;
        repeat (10) begin
            svc = 1; cyc(1); svc = 0;
            repeat (20) begin cyc(1); n += (hw === 1'b1); end
        end
        chk(n, 0);
        n = 0; while (hw !== 1'b1 && n < 70) begin cyc(1); n++; end
        chk(n >= 21 && n <= 30, 1);
    endtask
    task automatic t_tog;
        cyc(40); chk(oe_n[39], 1);
        jmp = 1; cyc(31); chk(oe_n[39], 0);
        cyc(100); chk(oe_n[39], 1);
        wr = 1; msk = 64'h0000_0080_0000_0000; dat = msk; cyc(1);
        wr = 0; chk(oe_n, 64'hff00_ff7f_ffff_ffff);
    endtask
    task automatic t_sync;
        sync = 1; cyc(1);
        sync = 0; cyc(9); chk(tick, 0);
        cyc(1); chk(tick, 1);
    endtask
    task automatic t_port;
        psw = 0; cyc(1); chk({pcon, pled}, 0);
        psw = 1; pact = 0; cyc(1); chk({pcon, pled}, 2);
        pact = 1; cyc(1); chk({pcon, pled}, 3);
        chk(fo, 0);
    endtask
    task automatic t_loss;
        alive = 0; cyc(260);
        chk(oe_n, '1);
        chk(st[0], 1);
        alive = 1; cyc(60); chk(oe_n, 64'hff00_ff7f_ffff_ffff);
        chk(st, 8'h03);
        sreq = 1; cyc(1);
        sreq = 0; cyc(1); chk(st, 8'h02);
    endtask
    initial begin
        cyc(3); chk(oe_n, '1);
        chk(st, 8'h03);
        rst_b = 1; cyc(1);
        t_out; t_misc; t_wd; t_tog; t_sync; t_port; t_loss;
        close_out;
    end
    initial begin
        #100us; failures++;
        close_out;
    end
endmodule
`default_nettype wire
